// ==== logic/pssl_loader.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - serial bits shift into the chain on the link clock and the transfer strobe moves them to the chain outputs.
// - after reset a trigger fires once so a full enable and load sequence delivers the current word.
// - while the change strobe is high the chain outputs toward the latches stay disabled.
// - once the change strobe is low the outputs are enabled only after one second, unless the bypass input is set.
// - every new change restarts the one second wait, so fast changes give no update.
// - a bypass input skips the one second settling wait.
// - after the wait the latch load is held off by 0.1 ms so bits can reach the latches.
// - the latches close 1 ms after the load step and hold the word until the next load.
module pssl_loader #(
    parameter int WORD_W      = pssl_pkg::WORD_W,
    parameter int SETTLE_CYC  = pssl_pkg::SETTLE_CYC,
    parameter int HOLDOFF_CYC = pssl_pkg::HOLDOFF_CYC,
    parameter int LATCH_CYC   = pssl_pkg::LATCH_CYC
) (
    input  wire logic              clock_in,               // system clock
    input  wire logic              nrst_in,                // async reset, low
    input  wire logic              link_clk_in,            // serial shift clock
    input  wire logic              link_data_in,           // serial data
    input  wire logic              transfer_strobe_in,     // strobe 1, link domain
    input  wire logic              change_strobe_in,       // strobe 2, async
    input  wire logic              bypass_in,              // skip settle wait
    output logic                   register_enable_out,    // chain outputs enabled
    output logic                   latch_sequence_out,     // latches transparent
    output logic [WORD_W-1:0]      preselector_word_out    // parallel lines
);
    typedef logic [pssl_pkg::CNT_W-1:0] pssl_cnt_t;

    // link domain: shift chain and transfer register
    logic [WORD_W-1:0] serial_shift_chain_r;
    pssl_pkg::pssl_xfer_t xfer_r;
    logic              lrst_s1_r, lrst_s2_r;

    // link reset release synchroniser
    always_ff @(posedge link_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            lrst_s1_r <= 1'b0;
            lrst_s2_r <= 1'b0;
        end else begin
            lrst_s1_r <= 1'b1;
            lrst_s2_r <= lrst_s1_r;
        end
    end

    // shift in, transfer on strobe
    always_ff @(posedge link_clk_in or negedge lrst_s2_r) begin
        if (!lrst_s2_r) begin
            serial_shift_chain_r <= '0;
            xfer_r               <= '0;
        end else begin
            serial_shift_chain_r <= {serial_shift_chain_r[WORD_W-2:0], link_data_in};
            if (transfer_strobe_in) begin
                xfer_r.word <= serial_shift_chain_r;
                xfer_r.tog  <= ~xfer_r.tog;
            end
        end
    end

    // system domain synchronisers
    logic tog_s1_r, tog_s2_r, tog_s3_r;
    logic chg_s1_r, chg_s2_r;
    logic byp_s1_r, byp_s2_r;
    logic [WORD_W-1:0] chain_out_r;

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            tog_s1_r <= 1'b0;
            tog_s2_r <= 1'b0;
            tog_s3_r <= 1'b0;
            chg_s1_r <= 1'b0;
            chg_s2_r <= 1'b0;
            byp_s1_r <= 1'b0;
            byp_s2_r <= 1'b0;
        end else begin
            tog_s1_r <= xfer_r.tog;
            tog_s2_r <= tog_s1_r;
            tog_s3_r <= tog_s2_r;
            chg_s1_r <= change_strobe_in;
            chg_s2_r <= chg_s1_r;
            byp_s1_r <= bypass_in;
            byp_s2_r <= byp_s1_r;
        end
    end

    // word is stable for many cycles after toggle seen
    wire xfer_seen = tog_s2_r ^ tog_s3_r;

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            chain_out_r <= '0;
        end else if (xfer_seen) begin
            chain_out_r <= xfer_r.word;
        end
    end

    // power-up trigger, fires once after release
    logic por_done_r;
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            por_done_r <= 1'b0;
        end else begin
            por_done_r <= 1'b1;
        end
    end
    wire por_trig = ~por_done_r;

    // sequencer
    pssl_pkg::pssl_state_t state_r, state_nxt;
    pssl_cnt_t             cnt_r, cnt_nxt;
    logic                  enable_r, enable_nxt;
    logic                  latch_r, latch_nxt;
    logic [WORD_W-1:0]     word_r, word_nxt;

    function automatic logic cnt_done(input pssl_cnt_t c, input int lim);
        cnt_done = (c >= pssl_cnt_t'(lim - 1));
    endfunction : cnt_done

    wire settle_over = byp_s2_r | cnt_done(cnt_r, SETTLE_CYC);

    always_comb begin
        state_nxt  = state_r;
        cnt_nxt    = cnt_r + pssl_cnt_t'(1);
        enable_nxt = enable_r;
        latch_nxt  = latch_r;
        word_nxt   = word_r;
        if (chg_s2_r) begin
            state_nxt  = pssl_pkg::PSSL_SETTLE;
            cnt_nxt    = '0;
            enable_nxt = 1'b0;
            latch_nxt  = 1'b0;
        end else begin
            unique case (state_r)
                pssl_pkg::PSSL_IDLE: begin
                    cnt_nxt = '0;
                    if (por_trig) begin
                        state_nxt  = pssl_pkg::PSSL_SETTLE;
                        enable_nxt = 1'b0;
                    end
                end
                pssl_pkg::PSSL_SETTLE: begin
                    if (settle_over) begin
                        state_nxt  = pssl_pkg::PSSL_HOLDOFF;
                        cnt_nxt    = '0;
                        enable_nxt = 1'b1;
                    end
                end
                pssl_pkg::PSSL_HOLDOFF: begin
                    if (cnt_done(cnt_r, HOLDOFF_CYC)) begin
                        state_nxt = pssl_pkg::PSSL_LATCH;
                        cnt_nxt   = '0;
                        latch_nxt = 1'b1;
                    end
                end
                pssl_pkg::PSSL_LATCH: begin
                    word_nxt = chain_out_r;
                    if (cnt_done(cnt_r, LATCH_CYC)) begin
                        state_nxt = pssl_pkg::PSSL_IDLE;
                        cnt_nxt   = '0;
                        latch_nxt = 1'b0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_r  <= pssl_pkg::PSSL_IDLE;
            cnt_r    <= '0;
            enable_r <= 1'b0;
            latch_r  <= 1'b0;
            word_r   <= '0;
        end else begin
            state_r  <= state_nxt;
            cnt_r    <= cnt_nxt;
            enable_r <= enable_nxt;
            latch_r  <= latch_nxt;
            word_r   <= word_nxt;
        end
    end

    // outputs straight from flops
    assign register_enable_out  = enable_r;
    assign latch_sequence_out   = latch_r;
    assign preselector_word_out = word_r;
endmodule : pssl_loader

// ==== logic/pssl_pkg.sv ====
package pssl_pkg;
    // widths and timing of the loader
    localparam int WORD_W          = 24;
    localparam int CLK_HZ          = 250_000_000;
    localparam int SETTLE_MS       = 1000;
    localparam int HOLDOFF_US      = 100;
    localparam int LATCH_MS        = 1;
    localparam int SETTLE_CYC      = SETTLE_MS * (CLK_HZ / 1000);
    localparam int HOLDOFF_CYC     = HOLDOFF_US * (CLK_HZ / 1_000_000);
    localparam int LATCH_CYC       = LATCH_MS * (CLK_HZ / 1000);
    localparam int CNT_W           = 32;

    // sequencer states
    typedef enum logic [1:0] {
        PSSL_IDLE    = 2'b00,
        PSSL_SETTLE  = 2'b01,
        PSSL_HOLDOFF = 2'b10,
        PSSL_LATCH   = 2'b11
    } pssl_state_t;

    // word handed from link domain
    typedef struct packed {
        logic              tog;
        logic [WORD_W-1:0] word;
    } pssl_xfer_t;
endpackage : pssl_pkg

// ==== sim/pssl_checker.sv ====
`timescale 1ns/1ps
module pssl_checker #(
    parameter int WORD_W      = 24,
    parameter int SETTLE_CYC  = 200,
    parameter int HOLDOFF_CYC = 20,
    parameter int LATCH_CYC   = 30
) (
    input wire logic              clock_in,             // clk
    input wire logic              nrst_in,              // rst
    input wire logic              change_strobe_in,     // change
    input wire logic              bypass_in,            // bypass
    input wire logic              register_enable_out,  // enable
    input wire logic              latch_sequence_out,   // latch
    input wire logic [WORD_W-1:0] preselector_word_out  // word
);
    logic [15:0] lo_r;
    logic [15:0] en_r;
    logic [15:0] hi_r;
    // cycles since strobe low, enable high, latch open
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            lo_r <= 16'h0000;
            en_r <= 16'h0000;
            hi_r <= 16'h0000;
        end else begin
            lo_r <= change_strobe_in ? 16'h0000 : lo_r + 16'(lo_r != 16'hffff);
            en_r <= register_enable_out ? en_r + 16'h0001 : 16'h0000;
            hi_r <= latch_sequence_out ? hi_r + 16'h0001 : 16'h0000;
        end
    end
    default clocking @(posedge clock_in); endclocking
    default disable iff (!nrst_in);
    enable_gate_a: assert property (latch_sequence_out |-> register_enable_out)
        else $error("latch open while disabled");
    word_hold_a: assert property (!latch_sequence_out [*2] |-> $stable(preselector_word_out))
        else $error("word moved outside window");
    latch_width_a: assert property ($fell(latch_sequence_out) |-> hi_r == LATCH_CYC)
        else $error("latch window length");
    change_off_a: assert property (change_strobe_in [*4] |-> !register_enable_out && !latch_sequence_out)
        else $error("enabled during change");
    settle_min_a: assert property ($rose(register_enable_out) && !bypass_in |-> lo_r >= SETTLE_CYC)
        else $error("settle too short");
    settle_max_a: assert property (lo_r == SETTLE_CYC + 6 |-> register_enable_out)
        else $error("settle too long");
    holdoff_a: assert property ($rose(latch_sequence_out) |-> en_r inside {[HOLDOFF_CYC:HOLDOFF_CYC + 1]})
        else $error("holdoff length");
    bypass_fast_a: assert property (bypass_in && lo_r == 16'h0008 |-> register_enable_out)
        else $error("bypass slow");
endmodule : pssl_checker
bind pssl_loader pssl_checker #(.WORD_W(WORD_W), .SETTLE_CYC(SETTLE_CYC), .HOLDOFF_CYC(HOLDOFF_CYC),
    .LATCH_CYC(LATCH_CYC)) u_chk (.clock_in(clock_in), .nrst_in(nrst_in), .change_strobe_in(change_strobe_in),
    .bypass_in(bypass_in), .register_enable_out(register_enable_out), .latch_sequence_out(latch_sequence_out),
    .preselector_word_out(preselector_word_out));

// ==== sim/pssl_ctrl_model.sv ====
`timescale 1ns/1ps
module pssl_ctrl_model (
    output logic link_clk_out,  // frames only
    output logic link_data_out, // serial data
    output logic xfer_out       // transfer strobe
);
    // idle: clock parked, strobe low
    initial begin
        link_clk_out = 1'b0;
        link_data_out = 1'b0;
        xfer_out = 1'b0;
    end
    // three lead edges, word msb first, then the strobe edge
    task automatic send(input logic [pssl_pkg::WORD_W-1:0] w);
        #3;
        for (int i = 0; i < pssl_pkg::WORD_W + 4; i++) begin
            link_data_out = (i > 2 && i < pssl_pkg::WORD_W + 3) ? w[pssl_pkg::WORD_W + 2 - i] : ~link_data_out;
            xfer_out = (i == pssl_pkg::WORD_W + 3);
            #40 link_clk_out = 1'b1;
            #40 link_clk_out = 1'b0;
        end
        xfer_out = 1'b0;
        link_data_out = ~link_data_out; // no stale bit
    endtask : send
endmodule : pssl_ctrl_model

// ==== sim/pssl_loader_tb_top.sv ====
`timescale 1ns/1ps
module pssl_loader_tb_top;
    logic clock_in, nrst_in, change_strobe_in, bypass_in, lclk, ldat, xfer, en, lat;
    logic [23:0] word;
    int mismatches, compares, cyc, n;
    // clock and hang guard
    initial begin
        clock_in = 1'b0;
        forever #2 clock_in = ~clock_in;
    end
    always @(posedge clock_in) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            give_verdict();
        end
    end
    pssl_ctrl_model u_ctrl (.link_clk_out(lclk), .link_data_out(ldat), .xfer_out(xfer));
    pssl_loader #(.SETTLE_CYC(200), .HOLDOFF_CYC(20), .LATCH_CYC(30)) u_dut (.clock_in(clock_in),
        .nrst_in(nrst_in), .link_clk_in(lclk), .link_data_in(ldat), .transfer_strobe_in(xfer),
        .change_strobe_in(change_strobe_in), .bypass_in(bypass_in), .register_enable_out(en),
        .latch_sequence_out(lat), .preselector_word_out(word));
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : give_verdict
    // change strobe for ten cycles
    task automatic pulse;
        @(posedge clock_in);
        change_strobe_in <= 1'b1;
        repeat (10) @(posedge clock_in);
        change_strobe_in <= 1'b0;
        @(negedge clock_in);
        chk(24'(en), 24'h00_0000);
    endtask : pulse
    // count cycles until enable, then let the window pass
    task automatic load(input logic [23:0] w);
        n = 0;
        while (en !== 1'b1 && n < 1000) begin
            @(negedge clock_in);
            n++;
        end
        repeat (60) @(negedge clock_in);
        chk(word, w);
    endtask : load
    task automatic sc_settle(input logic [23:0] w);
        u_ctrl.send(w);
        pulse();
        load(w);
        chk(24'(n > 197 && n < 209), 24'h00_0001);
    endtask : sc_settle
    task automatic sc_retrig(input logic [23:0] old, input logic [23:0] w);
        u_ctrl.send(w);
        repeat (3) begin
            pulse();
            repeat (100) @(negedge clock_in);
            chk({word[23:1], en}, {old[23:1], 1'b0});
        end
        load(w);
    endtask : sc_retrig
    task automatic sc_bypass(input logic [23:0] w);
        @(posedge clock_in);
        bypass_in <= 1'b1;
        u_ctrl.send(w);
        pulse();
        load(w);
        chk(24'(n < 9), 24'h00_0001);
        @(posedge clock_in);
        bypass_in <= 1'b0;
    endtask : sc_bypass
    initial begin
        {nrst_in, change_strobe_in, bypass_in} = 3'h0;
        {mismatches, compares, cyc} = '0;
        repeat (16) @(posedge clock_in);
        nrst_in <= 1'b1;
        load(24'h00_0000);
        chk(24'(n > 197 && n < 209), 24'h00_0001);
        sc_settle(24'ha5_c33c);
        sc_retrig(24'ha5_c33c, 24'h0f_f0e1);
        sc_bypass(24'h5a_1234);
        give_verdict();
    end
endmodule : pssl_loader_tb_top
